// ### logic/serial_port_pkg.sv
// Overview of operation
// [R01] Three-bit sync serial level, zero disables
// [R02] Three-bit async serial level, zero disables
// [R03] Equal levels: sync serial request wins
// [R04] Vector resets to uninitialized value
// [R05] Software loads user vector at init
// [R06] Acknowledge drives vector, lsb marks source
// [R07] Vector lsb ignores writes, reads one
// [R08] Port data drives outputs, reads pins
// [R09] Assignment bit picks GPIO or sync serial
// [R10] Assignment bits map to serial pin functions
// [R11] Pin 2 becomes clock when enabled; the code also needs assignment bit 2 set
// [R12] Pin 7 becomes transmit when enabled
// [R13] Direction bit: zero input, one output
// [R14] Data pins swap roles by mode
// [R15] Clock pin direction by mode
// [R16] Select 0 output, fault, or slave select
// [R17] Transmit forces output; receive always input
// [R18] Software writes data before direction
// [R19] Slave select starts a sync transfer
// [R20] Unimplemented bits ignore writes, read zero
// [R21] Reset clears levels and port data
package serial_port_pkg;

   // Register offsets
   localparam logic [7:0] ADDR_IRQ_LEVEL_VECTOR = 8'h04;
   localparam logic [7:0] ADDR_PORT_DATA        = 8'h14;
   localparam logic [7:0] ADDR_PIN_CTRL         = 8'h16;

   // Field positions
   localparam int SYNC_LVL_LSB  = 11;
   localparam int ASYNC_LVL_LSB = 8;
   localparam int VEC_LSB       = 1;
   localparam int ASSIGN_LSB    = 8;

   // Pin indices
   localparam int PIN_MISO = 0;
   localparam int PIN_MOSI = 1;
   localparam int PIN_SCK  = 2;
   localparam int PIN_CS0  = 3;
   localparam int PIN_TXD  = 7;

   // Values after reset
   localparam logic [2:0] LVL_RESET    = 3'h0;
   localparam logic [6:0] VEC_RESET    = 7'h07;
   localparam logic [7:0] PORT_RESET   = 8'h00;
   localparam logic [7:0] ASSIGN_RESET = 8'h00;
   localparam logic [7:0] DIR_RESET    = 8'h00;

   // Outputs of the sync serial engine toward the pins
   typedef struct packed {
      logic       dout;
      logic       sck;
      logic [3:0] cs_n;
   } sync_to_pins_t;

   // Pin-side inputs toward the sync serial engine
   typedef struct packed {
      logic din;
      logic sck;
      logic ss_n;
      logic ss_start;
      logic mode_fault;
   } pins_to_sync_t;

endpackage : serial_port_pkg

// ### logic/serial_module_port_and_irq_ctrl.sv
`timescale 1ns/1ns
module serial_module_port_and_irq_ctrl (
   // Clock and reset
   input  wire logic                          clk,
   input  wire logic                          sys_rst,
   // Register port
   input  wire logic [7:0]                    addr,
   input  wire logic [15:0]                   wr_data,
   input  wire logic                          wr_strobe,
   input  wire logic                          rd_strobe,
   output logic      [15:0]                   rd_data,
   // Submodule status and requests
   input  wire logic                          sync_serial_enable,
   input  wire logic                          master_mode,
   input  wire logic                          async_tx_enable,
   input  wire logic                          async_tx_data,
   input  wire logic                          sync_irq_req,
   input  wire logic                          async_irq_req,
   input  wire serial_port_pkg::sync_to_pins_t sync_out,
   output serial_port_pkg::pins_to_sync_t      sync_in,
   output logic                               async_rx_data,
   // Interrupt request and acknowledge
   output logic      [2:0]                    irq_level,
   output logic                               irq_from_sync,
   input  wire logic                          iack,
   input  wire logic [2:0]                    iack_level,
   output logic      [7:0]                    vector_out,
   output logic                               vector_valid,
   // Port pins
   input  wire logic [7:0]                    pin_in,
   input  wire logic                          rxd_pin,
   output logic      [7:0]                    pin_out,
   output logic      [7:0]                    pin_oe
);

   logic [2:0]  sync_serial_irq_level;
   logic [2:0]  async_serial_irq_level;
   logic [6:0]  irq_vector_field;
   logic [7:0]  port_data;
   logic [7:0]  pin_assignment;
   logic [7:0]  pin_direction;
   logic [2:0]  next_sync_lvl;
   logic [2:0]  next_async_lvl;
   logic [6:0]  next_vec;
   logic [7:0]  next_port;
   logic [7:0]  next_assign;
   logic [7:0]  next_dir;
   logic [15:0] next_rd_data;

   // Register writes and read data
   always_comb begin
      next_sync_lvl  = sync_serial_irq_level;
      next_async_lvl = async_serial_irq_level;
      next_vec       = irq_vector_field;
      next_port      = port_data;
      next_assign    = pin_assignment;
      next_dir       = pin_direction;
      next_rd_data   = 16'h0000;
      if (wr_strobe) begin
         case (addr)
            serial_port_pkg::ADDR_IRQ_LEVEL_VECTOR: begin
               next_sync_lvl  = wr_data[serial_port_pkg::SYNC_LVL_LSB +: 3];
               next_async_lvl = wr_data[serial_port_pkg::ASYNC_LVL_LSB +: 3];
               next_vec       = wr_data[serial_port_pkg::VEC_LSB +: 7]; // R07
            end
            serial_port_pkg::ADDR_PORT_DATA: begin
               next_port = wr_data[7:0]; // R08
            end
            serial_port_pkg::ADDR_PIN_CTRL: begin
               next_assign = wr_data[serial_port_pkg::ASSIGN_LSB +: 8];
               next_dir    = wr_data[7:0];
            end
            default: begin
               next_port = port_data; // R20
            end
         endcase
      end
      if (rd_strobe) begin
         case (addr)
            serial_port_pkg::ADDR_IRQ_LEVEL_VECTOR: begin
               next_rd_data = {2'h0, sync_serial_irq_level,
                               async_serial_irq_level, irq_vector_field,
                               1'h1}; // R07 R20
            end
            serial_port_pkg::ADDR_PORT_DATA: begin
               next_rd_data = {8'h00, pin_in}; // R08
            end
            serial_port_pkg::ADDR_PIN_CTRL: begin
               next_rd_data = {pin_assignment, pin_direction};
            end
            default: begin
               next_rd_data = 16'h0000; // R20
            end
         endcase
      end
   end

   // Register storage
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sync_serial_irq_level  <= serial_port_pkg::LVL_RESET; // R21
         async_serial_irq_level <= serial_port_pkg::LVL_RESET; // R21
         irq_vector_field       <= serial_port_pkg::VEC_RESET; // R04
         port_data              <= serial_port_pkg::PORT_RESET; // R21
         pin_assignment         <= serial_port_pkg::ASSIGN_RESET;
         pin_direction          <= serial_port_pkg::DIR_RESET;
         rd_data                <= 16'h0000;
      end else begin
         sync_serial_irq_level  <= next_sync_lvl;
         async_serial_irq_level <= next_async_lvl;
         irq_vector_field       <= next_vec;
         port_data              <= next_port;
         pin_assignment         <= next_assign;
         pin_direction          <= next_dir;
         rd_data                <= next_rd_data;
      end
   end

   logic [2:0] sync_eff;
   logic [2:0] async_eff;
   logic [2:0] next_irq_level;
   logic       next_from_sync;
   logic [7:0] next_vector;
   logic       next_vector_valid;

   // Priority between the two submodules and vector supply
   always_comb begin
      sync_eff  = sync_irq_req ? sync_serial_irq_level : 3'h0; // R01
      async_eff = async_irq_req ? async_serial_irq_level : 3'h0; // R02
      if (sync_eff != 3'h0 && sync_eff >= async_eff) begin // R03
         next_irq_level = sync_eff;
         next_from_sync = 1'b1;
      end else begin
         next_irq_level = async_eff;
         next_from_sync = 1'b0;
      end
      next_vector       = vector_out;
      next_vector_valid = 1'b0;
      if (iack && iack_level == irq_level && irq_level != 3'h0) begin
         next_vector       = {irq_vector_field, irq_from_sync}; // R06
         next_vector_valid = 1'b1;
      end
   end

   // Interrupt state
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         irq_level     <= 3'h0;
         irq_from_sync <= 1'b0;
         vector_out    <= 8'h00;
         vector_valid  <= 1'b0;
      end else begin
         irq_level     <= next_irq_level;
         irq_from_sync <= next_from_sync;
         vector_out    <= next_vector;
         vector_valid  <= next_vector_valid;
      end
   end

   logic [7:0]                     sync_own;
   logic [7:0]                     next_pin_out;
   logic [7:0]                     next_pin_oe;
   logic                           cs0_prev;
   logic                           fault_cond;
   logic                           fault_prev;
   serial_port_pkg::pins_to_sync_t next_sync_in;

   // Ownership: assignment and enable, never for the transmit pin
   always_comb begin
      sync_own = pin_assignment & {8{sync_serial_enable}}; // R09 R10 R11
      sync_own[serial_port_pkg::PIN_TXD] = 1'b0; // R09
   end

   // Pin drive for general-purpose and upper chip selects
   genvar g;
   generate
      for (g = 4; g < 7; g++) begin : g_cs
         always_comb begin
            if (sync_own[g]) begin
               next_pin_out[g] = sync_out.cs_n[g-3];
               next_pin_oe[g]  = master_mode & pin_direction[g]; // R16
            end else begin
               next_pin_out[g] = port_data[g]; // R08
               next_pin_oe[g]  = pin_direction[g]; // R13
            end
         end
      end
   endgenerate

   // Pin drive for the data, clock, select 0 and transmit pins
   always_comb begin
      next_pin_out[3:0] = port_data[3:0];
      next_pin_oe[3:0]  = pin_direction[3:0]; // R13
      if (sync_own[serial_port_pkg::PIN_MISO]) begin
         next_pin_out[0] = sync_out.dout;
         next_pin_oe[0]  = !master_mode & pin_direction[0]; // R14
      end
      if (sync_own[serial_port_pkg::PIN_MOSI]) begin
         next_pin_out[1] = sync_out.dout;
         next_pin_oe[1]  = master_mode & pin_direction[1]; // R14
      end
      if (sync_own[serial_port_pkg::PIN_SCK]) begin
         next_pin_out[2] = sync_out.sck;
         next_pin_oe[2]  = master_mode & pin_direction[2]; // R15
      end
      if (sync_own[serial_port_pkg::PIN_CS0]) begin
         next_pin_out[3] = sync_out.cs_n[0];
         next_pin_oe[3]  = master_mode & pin_direction[3]; // R16
      end
      if (async_tx_enable) begin
         next_pin_out[7] = async_tx_data; // R12
         next_pin_oe[7]  = 1'b1; // R17
      end else begin
         next_pin_out[7] = port_data[7];
         next_pin_oe[7]  = pin_direction[7]; // R17
      end
   end

   // Inputs toward the sync serial engine
   always_comb begin
      next_sync_in = '0;
      next_sync_in.ss_n = 1'b1;
      if (master_mode) begin
         next_sync_in.din = sync_own[0] & !pin_direction[0] & pin_in[0];
      end else begin
         next_sync_in.din = sync_own[1] & !pin_direction[1] & pin_in[1];
         if (sync_own[2] && !pin_direction[2]) begin
            next_sync_in.sck = pin_in[2]; // R15
         end
         if (sync_own[3] && !pin_direction[3]) begin
            next_sync_in.ss_n = pin_in[3]; // R16
         end
      end
      next_sync_in.ss_start = cs0_prev & !next_sync_in.ss_n; // R19
      fault_cond = master_mode & sync_own[3] & !pin_direction[3]
                   & !pin_in[3];
      next_sync_in.mode_fault = fault_cond & !fault_prev; // R16
   end

   // Pin and engine-side registers
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pin_out       <= 8'h00;
         pin_oe        <= 8'h00;
         sync_in       <= '{din: 1'b0, sck: 1'b0, ss_n: 1'b1,
                            ss_start: 1'b0, mode_fault: 1'b0};
         cs0_prev      <= 1'b1;
         fault_prev    <= 1'b0;
         async_rx_data <= 1'b1;
      end else begin
         pin_out       <= next_pin_out;
         pin_oe        <= next_pin_oe;
         sync_in       <= next_sync_in;
         cs0_prev      <= next_sync_in.ss_n;
         fault_prev    <= fault_cond;
         async_rx_data <= rxd_pin; // R17
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   tie_sync_wins_a: assert property ( // R03
      sync_irq_req && async_irq_req && sync_serial_irq_level != 3'h0 &&
      sync_serial_irq_level == async_serial_irq_level
      |=> irq_from_sync && irq_level == $past(sync_serial_irq_level))
      else $error("sync request lost a tie");

   sync_zero_off_a: assert property ( // R01
      !async_irq_req && sync_serial_irq_level == 3'h0 |=> irq_level == 3'h0)
      else $error("level zero still requests");

   async_level_a: assert property ( // R02
      async_irq_req && !sync_irq_req && async_serial_irq_level != 3'h0
      |=> !irq_from_sync && irq_level == $past(async_serial_irq_level))
      else $error("async level wrong");

   ack_vector_a: assert property ( // R06
      iack && iack_level == irq_level && irq_level != 3'h0
      |=> vector_valid && vector_out[7:1] == $past(irq_vector_field)
          && vector_out[0] == $past(irq_from_sync))
      else $error("vector wrong on acknowledge");

   vec_lsb_one_a: assert property ( // R07
      rd_strobe && addr == serial_port_pkg::ADDR_IRQ_LEVEL_VECTOR
      |=> rd_data[0] && rd_data[15:14] == 2'h0)
      else $error("vector lsb not one");

   port_read_a: assert property ( // R08
      rd_strobe && addr == serial_port_pkg::ADDR_PORT_DATA
      |=> rd_data == {8'h00, $past(pin_in)})
      else $error("port read not pin levels");

   gpio_drive_a: assert property ( // R13
      !pin_assignment[4] |=> pin_oe[4] == $past(pin_direction[4])
                             && pin_out[4] == $past(port_data[4]))
      else $error("gpio pin drive wrong");

   tx_forced_a: assert property ( // R17
      async_tx_enable |=> pin_oe[7] && pin_out[7] == $past(async_tx_data))
      else $error("transmit pin not output");

   slave_cs_off_a: assert property ( // R16
      sync_serial_enable && !master_mode && pin_assignment[5]
      |=> !pin_oe[5])
      else $error("slave chip select driven");

   sck_master_a: assert property ( // R15
      sync_serial_enable && master_mode && pin_assignment[2]
      |=> pin_oe[2] == $past(pin_direction[2])
          && pin_out[2] == $past(sync_out.sck))
      else $error("clock pin drive wrong");

   unmapped_read_a: assert property ( // R20
      rd_strobe && addr != serial_port_pkg::ADDR_IRQ_LEVEL_VECTOR
      && addr != serial_port_pkg::ADDR_PORT_DATA
      && addr != serial_port_pkg::ADDR_PIN_CTRL |=> rd_data == 16'h0000)
      else $error("unmapped read not zero");

   rd_idle_zero_a: assert property ( // R20
      !rd_strobe |=> rd_data == 16'h0000)
      else $error("read data without strobe");

   pin_ctrl_read_a: assert property ( // R09
      rd_strobe && addr == serial_port_pkg::ADDR_PIN_CTRL
      |=> rd_data == {$past(pin_assignment), $past(pin_direction)})
      else $error("pin control read wrong");

   mode_fault_a: assert property ( // R16
      sync_in.mode_fault |-> $past(master_mode) && $past(sync_serial_enable)
      && !$past(pin_direction[3]) && !$past(pin_in[3]))
      else $error("mode fault without select");

   ss_start_a: assert property ( // R19
      sync_in.ss_start |-> !sync_in.ss_n && !$past(master_mode))
      else $error("transfer start outside slave");

   slave_select_a: assert property ( // R16
      !master_mode && sync_serial_enable && pin_assignment[3]
      && !pin_direction[3] |=> sync_in.ss_n == $past(pin_in[3]))
      else $error("slave select not followed");

   miso_in_a: assert property ( // R14
      master_mode && sync_serial_enable && pin_assignment[0]
      && !pin_direction[0]
      |=> sync_in.din == $past(pin_in[0]) && !pin_oe[0])
      else $error("master data input wrong");

   mosi_out_a: assert property ( // R14
      master_mode && sync_serial_enable && pin_assignment[1]
      |=> pin_oe[1] == $past(pin_direction[1])
          && pin_out[1] == $past(sync_out.dout))
      else $error("master data output wrong");

   cs_master_a: assert property ( // R10
      master_mode && sync_serial_enable && pin_assignment[6]
      |=> pin_oe[6] == $past(pin_direction[6])
          && pin_out[6] == $past(sync_out.cs_n[3]))
      else $error("chip select drive wrong");

   pin2_gpio_a: assert property ( // R11
      !sync_serial_enable |=> pin_oe[2] == $past(pin_direction[2])
                              && pin_out[2] == $past(port_data[2]))
      else $error("pin 2 not general purpose");

   pin7_gpio_a: assert property ( // R12
      !async_tx_enable |=> pin_oe[7] == $past(pin_direction[7])
                           && pin_out[7] == $past(port_data[7]))
      else $error("pin 7 not general purpose");

   rx_follow_a: assert property ( // R17
      1'b1 |=> async_rx_data == $past(rxd_pin))
      else $error("receive input not followed");

endmodule : serial_module_port_and_irq_ctrl

// ### sim/ext_pins_model.sv
`timescale 1ns/1ns
module ext_pins_model (
   // Levels the device puts on its pins
   input  wire logic [7:0] pin_out,
   input  wire logic [7:0] pin_oe,
   // Peripheral drive on the same lines
   input  wire logic [7:0] ext_en,
   input  wire logic [7:0] ext_val,
   // Resolved wire levels
   output logic      [7:0] pin_in
);
   // Device wins where it drives; pull-ups lift lines nobody drives
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         pin_in[i] = pin_oe[i] ? pin_out[i]
                   : (ext_en[i] ? ext_val[i] : 1'b1);
      end
   end
endmodule : ext_pins_model

// ### sim/testbench.sv
`timescale 1ns/1ns
module testbench;
   logic clk, sys_rst, wr_strobe, rd_strobe, iack, rxd_pin;
   logic sync_serial_enable, master_mode, async_tx_enable;
   logic async_tx_data, sync_irq_req, async_irq_req, async_rx_data;
   logic irq_from_sync, vector_valid;
   logic [7:0] addr, vector_out, pin_in, pin_out, pin_oe, ext_val;
   logic [15:0] wr_data, rd_data;
   logic [2:0] iack_level, irq_level;
   serial_port_pkg::sync_to_pins_t sync_out;
   serial_port_pkg::pins_to_sync_t sync_in;
   int num_errors = 0;
   int cmp_count = 0;
   int cycles = 0;
   int nf = 0;
   int ns = 0;

   serial_module_port_and_irq_ctrl dut_u (.clk(clk), .sys_rst(sys_rst),
      .addr(addr), .wr_data(wr_data), .wr_strobe(wr_strobe),
      .rd_strobe(rd_strobe), .rd_data(rd_data),
      .sync_serial_enable(sync_serial_enable), .master_mode(master_mode),
      .async_tx_enable(async_tx_enable), .async_tx_data(async_tx_data),
      .sync_irq_req(sync_irq_req), .async_irq_req(async_irq_req),
      .sync_out(sync_out), .sync_in(sync_in),
      .async_rx_data(async_rx_data), .irq_level(irq_level),
      .irq_from_sync(irq_from_sync), .iack(iack), .iack_level(iack_level),
      .vector_out(vector_out), .vector_valid(vector_valid),
      .pin_in(pin_in), .rxd_pin(rxd_pin), .pin_out(pin_out),
      .pin_oe(pin_oe));

   ext_pins_model peer_u (.pin_out(pin_out), .pin_oe(pin_oe),
      .ext_en(8'hff), .ext_val(ext_val), .pin_in(pin_in));

   // Clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // Pulse counters and hang guard
   always @(posedge clk) begin
      cycles++;
      if (sync_in.mode_fault === 1'b1) nf++;
      if (sync_in.ss_start === 1'b1) ns++;
      if (cycles == 2000) begin
         num_errors++;
         tally_and_finish();
      end
   end

   task automatic chk(input string nm, input logic [15:0] seen,
                      input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wr_data <= d;
      wr_strobe <= 1'b1;
      @(posedge clk);
      wr_strobe <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [15:0] exp);
      @(posedge clk);
      addr <= a;
      rd_strobe <= 1'b1;
      @(posedge clk);
      rd_strobe <= 1'b0;
      #1 chk("rd_data", rd_data, exp);
   endtask : rd

   task automatic settle();
      repeat (3) @(posedge clk);
      #1;
   endtask : settle

   // Acknowledge a level and check the supplied vector
   task automatic ack(input logic [2:0] l, input logic ok,
                      input logic [7:0] v);
      @(posedge clk);
      iack <= 1'b1;
      iack_level <= l;
      @(posedge clk);
      iack <= 1'b0;
      #1 chk("vector_valid", 16'(vector_valid), 16'(ok));
      if (ok) chk("vector_out", 16'(vector_out), 16'(v));
   endtask : ack

   task automatic chk_irq(input logic [2:0] l, input logic s);
      settle();
      chk("irq_level", 16'(irq_level), 16'(l));
      chk("irq_from_sync", 16'(irq_from_sync), 16'(s));
   endtask : chk_irq

   task automatic tally_and_finish();
      $display("errors %0d comparisons %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : tally_and_finish

   // Main sequence
   initial begin
      sys_rst = 1'b1; addr = 8'h00; wr_data = 16'h0000;
      wr_strobe = 1'b0; rd_strobe = 1'b0; iack = 1'b0; iack_level = 3'h0;
      sync_serial_enable = 1'b0; master_mode = 1'b0; rxd_pin = 1'b1;
      async_tx_enable = 1'b0; async_tx_data = 1'b0; ext_val = 8'h00;
      sync_irq_req = 1'b0; async_irq_req = 1'b0; sync_out = '0;
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      // Reset contents and unmapped space
      rd(8'h04, 16'h000f);
      rd(8'h14, 16'h0000);
      rd(8'h16, 16'h0000);
      rd(8'h02, 16'h0000);
      wr(8'h04, 16'hffff);
      rd(8'h04, 16'h3fff);
      wr(8'h04, 16'h2b40);
      rd(8'h04, 16'h2b41);
      // Level arbitration and vectors
      async_irq_req <= 1'b1;
      chk_irq(3'h3, 1'b0);
      sync_irq_req <= 1'b1;
      chk_irq(3'h5, 1'b1);
      ack(3'h5, 1'b1, 8'h41);
      ack(3'h3, 1'b0, 8'h00);
      wr(8'h04, 16'h2d40);
      chk_irq(3'h5, 1'b1);
      sync_irq_req <= 1'b0;
      chk_irq(3'h5, 1'b0);
      ack(3'h5, 1'b1, 8'h40);
      wr(8'h04, 16'h0540);
      sync_irq_req <= 1'b1;
      chk_irq(3'h5, 1'b0);
      async_irq_req <= 1'b0;
      chk_irq(3'h0, 1'b0);
      sync_irq_req <= 1'b0;
      // Port data before direction, then pins read back
      wr(8'h14, 16'h00a5);
      wr(8'h16, 16'h00ff);
      settle();
      chk("pin_out", 16'(pin_out), 16'h00a5);
      chk("pin_oe", 16'(pin_oe), 16'h00ff);
      rd(8'h14, 16'h00a5);
      ext_val <= 8'hcb;
      wr(8'h16, 16'h000f);
      settle();
      rd(8'h14, 16'h00c5);
      // Assigned pins stay GPIO until the engine is enabled
      sync_out <= '{dout: 1'b1, sck: 1'b1, cs_n: 4'hb};
      master_mode <= 1'b1;
      wr(8'h16, 16'h7f7e);
      settle();
      chk("pin_oe", 16'(pin_oe), 16'h007e);
      chk("gpio_out", 16'(pin_out & pin_oe), 16'h0024);
      sync_serial_enable <= 1'b1;
      settle();
      chk("pin_oe", 16'(pin_oe), 16'h007e);
      chk("master_out", 16'(pin_out & pin_oe), 16'h005e);
      chk("din", 16'(sync_in.din), 16'h0001);
      // Select input asserted in master mode
      wr(8'h16, 16'h7f76);
      settle();
      ext_val <= 8'hc3;
      settle();
      chk("mode_fault", 16'(nf), 16'h0001);
      // Slave mode roles
      ext_val <= 8'hcf;
      master_mode <= 1'b0;
      wr(8'h16, 16'h7f01);
      settle();
      chk("pin_oe", 16'(pin_oe), 16'h0001);
      chk("slave_out", 16'(pin_out & pin_oe), 16'h0001);
      chk("sck_in", 16'(sync_in.sck), 16'h0001);
      chk("din", 16'(sync_in.din), 16'h0001);
      chk("ss_n", 16'(sync_in.ss_n), 16'h0001);
      ext_val <= 8'hc7;
      settle();
      chk("ss_start", 16'(ns), 16'h0001);
      chk("ss_n", 16'(sync_in.ss_n), 16'h0000);
      // Transmitter takes pin 7 though its direction bit is zero
      async_tx_enable <= 1'b1;
      rxd_pin <= 1'b0;
      settle();
      chk("tx_pin", 16'({pin_oe[7], pin_out[7]}), 16'h0002);
      chk("rx", 16'(async_rx_data), 16'h0000);
      async_tx_data <= 1'b1;
      settle();
      chk("tx_pin", 16'({pin_oe[7], pin_out[7]}), 16'h0003);
      tally_and_finish();
   end
endmodule : testbench
